// ==== afc_pkg.sv ====
// Shared constants and carrier types for the amplifier front-end register bank
package afc_pkg;

   // Bus geometry
   localparam int AFC_AW = 12;
   localparam int AFC_DW = 32;
   localparam int AFC_NLANE = 4;

   // Register byte offsets
   localparam logic [AFC_AW-1:0] AFC_OFS_CHOP0 = 12'h024;
   localparam logic [AFC_AW-1:0] AFC_OFS_AMP1 = 12'h070;

   // Reset values
   localparam logic [AFC_DW-1:0] AFC_RST_CHOP0 = 32'h0000_0001;
   localparam logic [AFC_DW-1:0] AFC_RST_AMP1 = 32'h0000_0011;

   // Writable bits; everything else reads zero
   localparam logic [AFC_DW-1:0] AFC_WMASK_CHOP0 = 32'h0000_0001;
   localparam logic [AFC_DW-1:0] AFC_WMASK_AMP1 = 32'h0000_7FFF;

   // Field positions
   localparam int AFC_BIT_CHOP_DIS = 0;
   localparam int AFC_BIT_PWRDN = 0;
   localparam int AFC_BIT_FUNC = 1;
   localparam int AFC_BIT_COUPLING = 2;
   localparam int AFC_LSB_RSVD_LO = 3;
   localparam int AFC_MSB_RSVD_LO = 4;
   localparam int AFC_LSB_GAIN = 5;
   localparam int AFC_MSB_GAIN = 7;
   localparam int AFC_LSB_RES = 8;
   localparam int AFC_MSB_RES = 10;
   localparam int AFC_LSB_BIAS = 11;
   localparam int AFC_MSB_BIAS = 12;
   localparam int AFC_BIT_RSVD13 = 13;
   localparam int AFC_BIT_BOOST = 14;
   localparam int AFC_MSB_USED = 14;

   // Highest defined codes
   localparam logic [2:0] AFC_GAIN_MAX = 3'h5;
   localparam logic [2:0] AFC_RES_MAX = 3'h6;

   // Bias source codes
   typedef enum logic [1:0] {
      AFC_BIAS_DAC_A = 2'h0,
      AFC_BIAS_DAC_B = 2'h1,
      AFC_BIAS_DAC_C = 2'h2,
      AFC_BIAS_DAC_D = 2'h3
   } afc_bias_e;

   // Channel 1 control, bits 14..0
   typedef struct packed {
      logic sink_boost_en;
      logic rsvd13;
      logic [1:0] transimp_bias_sel;
      logic [2:0] transimp_resistor_sel;
      logic [2:0] amp_gain_sel;
      logic [1:0] rsvd_lo;
      logic coupling_sel;
      logic func_sel;
      logic amp_core_powerdown;
   } afc_amp1_cfg_s;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [AFC_AW-1:0] paddr;
      logic [AFC_DW-1:0] pwdata;
      logic [AFC_NLANE-1:0] pstrb;
   } afc_apb_req_s;

endpackage

// ==== afc_wreg.sv ====
// Byte-lane writable register with a mask of implemented bits
`timescale 1ns/100ps
module afc_wreg #(
   parameter logic [31:0] RST_VAL = 32'h0000_0000,
   parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // Write port
   input wire logic i_we,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_strb,
   // Stored value
   output logic [31:0] o_q
);

   logic [31:0] val_q;
   logic [31:0] val_d;

   // Unimplemented bits never store anything
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign val_d[g*8 +: 8] = (i_we && i_strb[g]) ?
            (i_wdata[g*8 +: 8] & WMASK[g*8 +: 8]) : val_q[g*8 +: 8];
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         val_q <= RST_VAL;
      end else begin
         val_q <= val_d;
      end
   end

   assign o_q = val_q;

endmodule

// ==== afc_regs.sv ====
// APB register bank for the amplifier front-end configuration
//
// Function
// - Channel 0 chop register at 0x24, resets to 0x00000001 (chop off).
// - Chop register bit 0 read-write; 0 chops, 1 disables chopping.
// - Channel 1 control register at 0x70, resets to 0x00000011.
// - Bit 14 read-write sink-current boost, reset 0 normal drive.
// - Bits 12:11 pick bias source DAC a to d, reset 0.
// - Bits 10:8 pick transimpedance resistor, 111 undefined, reset 0.
// - Bits 7:5 set amplifier gain, 110 and 111 undefined, reset 0.
// - Bit 2 coupling, 0 DC, 1 AC, reset 0.
// - Bit 1 function, 0 voltage amplifier, 1 transimpedance, reset 0.
// - Bit 0 core power-down, resets 1; writing 0 enables amplifier.
`timescale 1ns/100ps
module afc_regs (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // APB slave
   input wire afc_pkg::afc_apb_req_s i_apb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Channel 0 chop control
   output logic o_chop_disable,
   output logic o_sample_time_x2,
   // Channel 1 configuration
   output afc_pkg::afc_amp1_cfg_s o_amp1_cfg,
   output logic [3:0] o_bias_dac_sel,
   output logic o_gain_code_ok,
   output logic o_resistor_code_ok
);

   // Word match, byte offset bits ignored
   function automatic logic f_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr[11:2] == ofs[11:2];
   endfunction

   // Bias code to one-hot DAC select
   function automatic logic [3:0] f_bias_onehot(input logic [1:0] code);
      logic [3:0] oh;
      oh = 4'h0;
      case (afc_pkg::afc_bias_e'(code))
         afc_pkg::AFC_BIAS_DAC_A: oh = 4'h1;
         afc_pkg::AFC_BIAS_DAC_B: oh = 4'h2;
         afc_pkg::AFC_BIAS_DAC_C: oh = 4'h4;
         afc_pkg::AFC_BIAS_DAC_D: oh = 4'h8;
         default: oh = 4'h0;
      endcase
      return oh;
   endfunction

   // Bus phase decode
   wire logic setup_ph;
   wire logic access_ph;
   wire logic hit_chop;
   wire logic hit_amp1;
   wire logic hit_any;
   wire logic wr_chop;
   wire logic wr_amp1;
   wire logic [31:0] chop_reg;
   wire logic [31:0] amp1_reg;
   wire logic [31:0] rd_mux;
   wire afc_pkg::afc_amp1_cfg_s amp1_fld;

   assign setup_ph = i_apb.psel && !i_apb.penable;
   assign access_ph = i_apb.psel && i_apb.penable;
   assign hit_chop = f_hit(i_apb.paddr, afc_pkg::AFC_OFS_CHOP0);
   assign hit_amp1 = f_hit(i_apb.paddr, afc_pkg::AFC_OFS_AMP1);
   assign hit_any = hit_chop || hit_amp1;

   // Zero wait states, so a write lands on the access edge
   assign wr_chop = access_ph && i_apb.pwrite && hit_chop;
   assign wr_amp1 = access_ph && i_apb.pwrite && hit_amp1;

   // Chop register: only bit 0 exists
   afc_wreg #(
      .RST_VAL(afc_pkg::AFC_RST_CHOP0),
      .WMASK(afc_pkg::AFC_WMASK_CHOP0)
   ) u_amp0_chop_ctrl (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_we(wr_chop),
      .i_wdata(i_apb.pwdata),
      .i_strb(i_apb.pstrb),
      .o_q(chop_reg)
   );

   // Channel 1 control: bits 14..0, bits 13 and 4:3 are plain storage
   afc_wreg #(
      .RST_VAL(afc_pkg::AFC_RST_AMP1),
      .WMASK(afc_pkg::AFC_WMASK_AMP1)
   ) u_amp1_ctrl (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_we(wr_amp1),
      .i_wdata(i_apb.pwdata),
      .i_strb(i_apb.pstrb),
      .o_q(amp1_reg)
   );

   assign amp1_fld = afc_pkg::afc_amp1_cfg_s'(amp1_reg[afc_pkg::AFC_MSB_USED:0]);

   // Read data and error are set up in the setup cycle
   assign rd_mux = hit_chop ? chop_reg : (hit_amp1 ? amp1_reg : 32'h0000_0000);

   logic [31:0] prdata_q;
   logic pslverr_q;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_ph) begin
         prdata_q <= i_apb.pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_q <= !hit_any;
      end
   end

   assign o_pready = access_ph;
   assign o_prdata = prdata_q;
   assign o_pslverr = access_ph && pslverr_q;

   // Derived status, one cycle behind the register
   logic sample_x2_q;
   logic [3:0] bias_oh_q;
   logic gain_ok_q;
   logic res_ok_q;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         sample_x2_q <= 1'b0;
         bias_oh_q <= 4'h1;
         gain_ok_q <= 1'b1;
         res_ok_q <= 1'b1;
      end else begin
         sample_x2_q <= !chop_reg[afc_pkg::AFC_BIT_CHOP_DIS];
         bias_oh_q <= f_bias_onehot(amp1_fld.transimp_bias_sel);
         gain_ok_q <= amp1_fld.amp_gain_sel <= afc_pkg::AFC_GAIN_MAX;
         res_ok_q <= amp1_fld.transimp_resistor_sel <= afc_pkg::AFC_RES_MAX;
      end
   end

   // Undefined codes are passed through; the flags let the analog side guard
   assign o_chop_disable = chop_reg[afc_pkg::AFC_BIT_CHOP_DIS];
   assign o_sample_time_x2 = sample_x2_q;
   assign o_amp1_cfg = amp1_fld;
   assign o_bias_dac_sel = bias_oh_q;
   assign o_gain_code_ok = gain_ok_q;
   assign o_resistor_code_ok = res_ok_q;

   // Checks
   sequence s_wr_chop;
      access_ph && i_apb.pwrite && hit_chop && i_apb.pstrb[0];
   endsequence

   sequence s_wr_amp1_lo;
      access_ph && i_apb.pwrite && hit_amp1 && i_apb.pstrb[0];
   endsequence

   sequence s_wr_amp1_hi;
      access_ph && i_apb.pwrite && hit_amp1 && i_apb.pstrb[1];
   endsequence

   sequence s_rd_setup(logic hit);
      setup_ph && !i_apb.pwrite && hit;
   endsequence

   property p_reset_vals;
      @(posedge i_clk_sys)
      $rose(i_nrst) |->
         chop_reg == afc_pkg::AFC_RST_CHOP0 && amp1_reg == afc_pkg::AFC_RST_AMP1;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("register reset value wrong");

   property p_chop_write;
      logic b;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_chop, b = i_apb.pwdata[0]) |=>
         o_chop_disable == b ##1 o_sample_time_x2 == !b;
   endproperty
   a_chop_write: assert property (p_chop_write)
      else $error("chop control did not follow write");

   property p_boost_write;
      logic b;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_amp1_hi, b = i_apb.pwdata[14]) |=> o_amp1_cfg.sink_boost_en == b;
   endproperty
   a_boost_write: assert property (p_boost_write)
      else $error("sink boost did not follow write");

   property p_bias_write;
      logic [1:0] c;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_amp1_hi, c = i_apb.pwdata[12:11]) |=>
         o_amp1_cfg.transimp_bias_sel == c ##1 o_bias_dac_sel == (4'h1 << c);
   endproperty
   a_bias_write: assert property (p_bias_write)
      else $error("bias source select wrong");

   property p_res_write;
      logic [2:0] c;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_amp1_hi, c = i_apb.pwdata[10:8]) |=>
         o_amp1_cfg.transimp_resistor_sel == c ##1 o_resistor_code_ok == (c != 3'h7);
   endproperty
   a_res_write: assert property (p_res_write)
      else $error("resistor select or code flag wrong");

   property p_gain_write;
      logic [2:0] c;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_amp1_lo, c = i_apb.pwdata[7:5]) |=>
         o_amp1_cfg.amp_gain_sel == c ##1 o_gain_code_ok == (c < 3'h6);
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("gain select or code flag wrong");

   property p_low_bits_write;
      logic [2:0] v;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_amp1_lo, v = i_apb.pwdata[2:0]) |=>
         {o_amp1_cfg.coupling_sel, o_amp1_cfg.func_sel,
          o_amp1_cfg.amp_core_powerdown} == v;
   endproperty
   a_low_bits_write: assert property (p_low_bits_write)
      else $error("coupling, function or power-down wrong");

   property p_rsvd_read_zero;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      s_rd_setup(hit_amp1) ##1 access_ph |->
         o_prdata[31:15] == 17'h0_0000 && o_prdata[14:0] == amp1_reg[14:0];
   endproperty
   a_rsvd_read_zero: assert property (p_rsvd_read_zero)
      else $error("channel 1 read data wrong");

   property p_chop_read;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      s_rd_setup(hit_chop) ##1 access_ph |->
         o_prdata == {31'h0000_0000, o_chop_disable};
   endproperty
   a_chop_read: assert property (p_chop_read)
      else $error("chop read data wrong");

   property p_rsvd_rw;
      logic [2:0] v;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      (s_wr_amp1_hi, v = {i_apb.pwdata[13], i_apb.pwdata[4:3]}) ##0
         i_apb.pstrb[0] |=> {o_amp1_cfg.rsvd13, o_amp1_cfg.rsvd_lo} == v;
   endproperty
   a_rsvd_rw: assert property (p_rsvd_rw)
      else $error("reserved read-write bits not stored");

   property p_hold_no_write;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      !(access_ph && i_apb.pwrite) |=> $stable(chop_reg) && $stable(amp1_reg);
   endproperty
   a_hold_no_write: assert property (p_hold_no_write)
      else $error("register changed without a write");

   property p_unmapped_err;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      setup_ph && !hit_any ##1 access_ph |-> o_pslverr && o_pready;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access not flagged");

   // Storage that must not move, and status that trails the fields
   sequence s_wr_unmapped;
      access_ph && i_apb.pwrite && !hit_any;
   endsequence

   sequence s_wr_amp1_keep_hi;
      access_ph && i_apb.pwrite && hit_amp1 && !i_apb.pstrb[1];
   endsequence

   property p_unmapped_no_write;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      s_wr_unmapped |=> $stable(chop_reg) && $stable(amp1_reg);
   endproperty
   a_unmapped_no_write: assert property (p_unmapped_no_write)
      else $error("unmapped write changed a register");

   property p_lane_keep;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      s_wr_amp1_keep_hi |=> $stable(amp1_reg[14:8]);
   endproperty
   a_lane_keep: assert property (p_lane_keep)
      else $error("unselected byte lane was written");

   property p_chop_rsvd_zero;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      chop_reg[31:1] == 31'h0000_0000;
   endproperty
   a_chop_rsvd_zero: assert property (p_chop_rsvd_zero)
      else $error("chop reserved bits not zero");

   property p_amp1_rsvd_zero;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      amp1_reg[31:15] == 17'h0_0000;
   endproperty
   a_amp1_rsvd_zero: assert property (p_amp1_rsvd_zero)
      else $error("channel 1 reserved bits not zero");

   // Bits 4:3 follow the whole-register reset value
   property p_reset_rsvd;
      @(posedge i_clk_sys)
      $rose(i_nrst) |->
         o_amp1_cfg.rsvd_lo == 2'h2 && o_amp1_cfg.rsvd13 == 1'b0;
   endproperty
   a_reset_rsvd: assert property (p_reset_rsvd)
      else $error("reserved bits reset wrong");

   property p_reset_status;
      @(posedge i_clk_sys)
      $rose(i_nrst) |->
         !o_sample_time_x2 && o_bias_dac_sel == 4'h1 &&
         o_gain_code_ok && o_resistor_code_ok;
   endproperty
   a_reset_status: assert property (p_reset_status)
      else $error("status outputs reset wrong");

   property p_x2_follows;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      1'b1 |=> o_sample_time_x2 == !$past(o_chop_disable);
   endproperty
   a_x2_follows: assert property (p_x2_follows)
      else $error("sample time flag does not track chop");

   property p_bias_follows;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      1'b1 |=> o_bias_dac_sel == (4'h1 << $past(o_amp1_cfg.transimp_bias_sel));
   endproperty
   a_bias_follows: assert property (p_bias_follows)
      else $error("bias select does not track bias code");

   property p_gain_ok_follows;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      1'b1 |=>
         o_gain_code_ok == !($past(o_amp1_cfg.amp_gain_sel) inside {3'h6, 3'h7});
   endproperty
   a_gain_ok_follows: assert property (p_gain_ok_follows)
      else $error("gain code flag does not track gain");

   property p_res_ok_follows;
      @(posedge i_clk_sys) disable iff (!i_nrst)
      1'b1 |=>
         o_resistor_code_ok == ($past(o_amp1_cfg.transimp_resistor_sel) != 3'h7);
   endproperty
   a_res_ok_follows: assert property (p_res_ok_follows)
      else $error("resistor code flag does not track resistor");

endmodule

// ==== test_afc_regs.sv ====
// Self-checking testbench for the amplifier front-end register bank
`timescale 1ns/100ps
module test_afc_regs;
   logic i_clk_sys = 1'b0;
   logic i_nrst = 1'b0;
   afc_pkg::afc_apb_req_s i_apb = '0;
   logic o_pready;
   logic [31:0] o_prdata;
   logic o_pslverr;
   logic o_chop_disable;
   logic o_sample_time_x2;
   afc_pkg::afc_amp1_cfg_s o_amp1_cfg;
   logic [3:0] o_bias_dac_sel;
   logic o_gain_code_ok;
   logic o_resistor_code_ok;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;

   always #2.5 i_clk_sys = ~i_clk_sys;

   afc_regs uut (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_apb(i_apb),
      .o_pready(o_pready),
      .o_prdata(o_prdata),
      .o_pslverr(o_pslverr),
      .o_chop_disable(o_chop_disable),
      .o_sample_time_x2(o_sample_time_x2),
      .o_amp1_cfg(o_amp1_cfg),
      .o_bias_dac_sel(o_bias_dac_sel),
      .o_gain_code_ok(o_gain_code_ok),
      .o_resistor_code_ok(o_resistor_code_ok)
   );

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard, well above the roughly 140 cycles the run needs
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the slave sets the pace, only the guard ends the wait
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      input logic [3:0] strb);
      @(posedge i_clk_sys);
      i_apb.psel <= 1'b1;
      i_apb.penable <= 1'b0;
      i_apb.pwrite <= wr;
      i_apb.paddr <= addr;
      i_apb.pwdata <= data;
      i_apb.pstrb <= strb;
      @(posedge i_clk_sys);
      i_apb.penable <= 1'b1;
      do begin
         @(posedge i_clk_sys);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_apb.psel <= 1'b0;
      i_apb.penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string what);
      apb(1'b0, addr, 32'h0000_0000, 4'h0);
      chk(what, exp, rd);
   endtask

   // Config outputs change on the access edge, derived flags one cycle after it
   task automatic settle();
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic t_reset();
      rd_chk(12'h024, 32'h0000_0001, "chop reset");
      rd_chk(12'h070, 32'h0000_0011, "amp1 reset");
      chk("chop out", 32'h1, {31'h0, o_chop_disable});
      chk("cfg out", 32'h0000_0011, {17'h0, o_amp1_cfg});
      chk("x2 out", 32'h0, {31'h0, o_sample_time_x2});
      chk("bias sel", 32'h1, {28'h0, o_bias_dac_sel});
   endtask

   task automatic t_chop();
      apb(1'b1, 12'h024, 32'h0000_0000, 4'hF);
      settle();
      chk("chop on", 32'h0, {31'h0, o_chop_disable});
      chk("x2 on", 32'h1, {31'h0, o_sample_time_x2});
      rd_chk(12'h024, 32'h0000_0000, "chop rd0");
      apb(1'b1, 12'h024, 32'hFFFF_FFFF, 4'hF);
      rd_chk(12'h024, 32'h0000_0001, "chop rsvd");
      settle();
      chk("chop off", 32'h1, {31'h0, o_chop_disable});
   endtask

   // Every code of every field except reserved bits 13 and 4:3, including the undefined ones
   task automatic t_fields();
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         d = (i << 5) | (i << 8) | ((i & 3) << 11) | ((i & 1) << 14) | ((i & 6) >> 1)
             | ((i & 1) << 2);
         apb(1'b1, 12'h070, d, 4'hF);
         settle();
         chk("cfg", d, {17'h0, o_amp1_cfg});
         chk("bias", 32'h1 << (i & 3), {28'h0, o_bias_dac_sel});
         chk("gain ok", (i <= 5), {31'h0, o_gain_code_ok});
         chk("res ok", (i <= 6), {31'h0, o_resistor_code_ok});
         rd_chk(12'h070, d, "amp1 rd");
      end
   endtask

   task automatic t_reserved();
      apb(1'b1, 12'h070, 32'hFFFF_FFFF, 4'hF);
      rd_chk(12'h070, 32'h0000_7FFF, "amp1 rsvd");
      // Only lane 1 cleared
      apb(1'b1, 12'h070, 32'h0000_0000, 4'h2);
      rd_chk(12'h070, 32'h0000_00FF, "amp1 lane");
      settle();
      chk("cfg lane", 32'h0000_00FF, {17'h0, o_amp1_cfg});
   endtask

   task automatic t_unmapped();
      apb(1'b1, 12'h028, 32'hFFFF_FFFF, 4'hF);
      chk("wr err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h100, 32'h0000_0000, 4'h0);
      chk("rd err", 32'h1, {31'h0, err});
      chk("rd zero", 32'h0, rd);
      rd_chk(12'h024, 32'h0000_0001, "chop kept");
      apb(1'b0, 12'h024, 32'h0000_0000, 4'h0);
      chk("no err", 32'h0, {31'h0, err});
   endtask

   // Reset in mid-run puts both registers and every derived output back
   task automatic t_midreset();
      apb(1'b1, 12'h024, 32'h0000_0000, 4'hF);
      apb(1'b1, 12'h070, 32'h0000_7FFE, 4'hF);
      apb(1'b1, 12'h070, 32'h0000_00E0, 4'h1);
      rd_chk(12'h070, 32'h0000_7FE0, "amp1 lane0");
      settle();
      chk("pready idle", 32'h0, {31'h0, o_pready});
      chk("gain bad", 32'h0, {31'h0, o_gain_code_ok});
      @(posedge i_clk_sys);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      rd_chk(12'h024, 32'h0000_0001, "chop rst2");
      rd_chk(12'h070, 32'h0000_0011, "amp1 rst2");
      chk("x2 rst2", 32'h0, {31'h0, o_sample_time_x2});
      chk("bias rst2", 32'h1, {28'h0, o_bias_dac_sel});
      chk("gain rst2", 32'h1, {31'h0, o_gain_code_ok});
      chk("res rst2", 32'h1, {31'h0, o_resistor_code_ok});
   endtask

   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      t_reset();
      t_chop();
      t_fields();
      t_reserved();
      t_unmapped();
      t_midreset();
      final_report();
   end
endmodule
